// *** include/timer_control_two_regs.vh ***
// register map, field positions and codes of the second timer control block
`ifndef TIMER_CONTROL_TWO_REGS_VH
`define TIMER_CONTROL_TWO_REGS_VH

`define ADDR_CONTROL_2      8'h04
`define ADDR_IRQ_STATUS     8'h08
`define ADDR_IRQ_MASK       8'h0C
`define ADDR_LINE_STATUS    8'h10
`define CONTROL_2_RESET     16'h0000
`define CONTROL_2_WMASK     16'hFF7D
`define IDLE_LSB            8
`define IDLE_MSB            15
`define MASTER_SEL_LSB      4
`define MASTER_SEL_MSB      6
`define DMA_SRC_BIT         3
`define PRELOAD_SRC_BIT     2
`define PRELOAD_EN_BIT      0
`define TRG_RESET           3'b000
`define TRG_ENABLE          3'b001
`define TRG_UPDATE          3'b010
`define TRG_MATCH_PULSE     3'b011
`define TRG_REF1            3'b100
`define TRG_REF2            3'b101
`define TRG_REF3            3'b110
`define TRG_REF4            3'b111
`define LOCK_OFF            2'b00
`define IRQ_BITS            4
`define IRQ_UPDATE          0
`define IRQ_MATCH           1
`define IRQ_TRIG_RISE       2
`define IRQ_PRELOAD         3
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// *** hw/master_trigger_select.v ***
// master trigger output selection from internal timer events
`timescale 1ns/1ps
`include "timer_control_two_regs.vh"

module master_trigger_select (
  // clock and reset
  input  wire       clk,
  input  wire       srst,
  // selection
  input  wire [2:0] mode,
  input  wire       masterSlave,
  // events
  input  wire       updateGenerate,
  input  wire       updateEvent,
  input  wire       counterEnableBit,
  input  wire       gatedMode,
  input  wire       triggerInput,
  input  wire       compareMatch,
  input  wire [3:0] compareRef,
  // result
  output reg        masterTriggerOut
);

  reg  triggerDelay_reg;
  reg  enableSignal;
  reg  masterTriggerNext;

  // trigger-driven enable is late by one cycle unless master/slave mode
  always @(posedge clk) begin
    if (srst) begin
      triggerDelay_reg <= 1'b0;
    end else begin
      triggerDelay_reg <= triggerInput;
    end
  end

  // counter-enable signal: software bit or gated trigger input
  always @* begin
    enableSignal = counterEnableBit | (gatedMode &
      (masterSlave ? triggerInput : triggerDelay_reg));
    case (mode)
      `TRG_RESET:       masterTriggerNext = updateGenerate;
      `TRG_ENABLE:      masterTriggerNext = enableSignal;
      `TRG_UPDATE:      masterTriggerNext = updateEvent;
      `TRG_MATCH_PULSE: masterTriggerNext = compareMatch;
      `TRG_REF1:        masterTriggerNext = compareRef[0];
      `TRG_REF2:        masterTriggerNext = compareRef[1];
      `TRG_REF3:        masterTriggerNext = compareRef[2];
      `TRG_REF4:        masterTriggerNext = compareRef[3];
      default:          masterTriggerNext = 1'b0;
    endcase
  end

  // registered so the slave timers see a glitch-free level
  always @(posedge clk) begin
    if (srst) begin
      masterTriggerOut <= 1'b0;
    end else begin
      masterTriggerOut <= masterTriggerNext;
    end
  end

endmodule

// *** hw/adv_timer_control_two.v ***
// second control register of the advanced timer with axi4-lite access
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "timer_control_two_regs.vh"

module adv_timer_control_two #(
  parameter CHANNELS = 4,
  parameter HAS_COMP = 4'b1111
) (
  // clock and reset
  input  wire                  clk,
  input  wire                  srst,
  // axi4-lite write address
  input  wire [7:0]            awaddr,
  input  wire                  awvalid,
  output reg                   awready,
  // axi4-lite write data
  input  wire [31:0]           wdata,
  input  wire [3:0]            wstrb,
  input  wire                  wvalid,
  output reg                   wready,
  // axi4-lite write response
  output reg  [1:0]            bresp,
  output reg                   bvalid,
  input  wire                  bready,
  // axi4-lite read
  input  wire [7:0]            araddr,
  input  wire                  arvalid,
  output reg                   arready,
  output reg  [31:0]           rdata,
  output reg  [1:0]            rresp,
  output reg                   rvalid,
  input  wire                  rready,
  // timer core state
  input  wire                  mainOutputEnable,
  input  wire [1:0]            lockLevel,
  input  wire                  counterEnableBit,
  input  wire                  gatedMode,
  input  wire                  masterSlave,
  input  wire                  triggerInput,
  input  wire                  updateGenerate,
  input  wire                  updateEvent,
  input  wire                  commutationGenerate,
  input  wire                  compareMatch,
  input  wire [CHANNELS-1:0]   compareRef,
  input  wire [CHANNELS-1:0]   capCompEvent,
  input  wire [CHANNELS-1:0]   activeMain,
  input  wire [CHANNELS-1:0]   activeComp,
  // outputs toward pins, slaves and dma
  output reg  [CHANNELS-1:0]   mainOutput,
  output reg  [CHANNELS-1:0]   compOutput,
  output wire                  masterTriggerOut,
  output reg  [CHANNELS-1:0]   dmaRequest,
  output reg                   preloadLoad,
  output reg                   preloadEnable,
  output reg                   irq
);

  // register state and bus holding
  reg  [15:0]         control2_reg;
  reg  [15:0]         control2_next;
  reg  [3:0]          irqStatus_reg;
  reg  [3:0]          irqMask_reg;
  reg                 awHeld_reg;
  reg                 wHeld_reg;
  reg  [7:0]          awAddr_reg;
  reg  [31:0]         wData_reg;
  reg  [3:0]          wStrb_reg;
  // trigger input synchroniser and edge detector
  reg                 trigSync1_reg;
  reg                 trigSync2_reg;
  reg                 trigLast_reg;
  // combinational helpers
  reg                 writeHit;
  reg  [3:0]          irqEvents;
  wire                trigRise;
  wire                doWrite;
  wire [CHANNELS-1:0] idleMain;
  wire [CHANNELS-1:0] idleComp;

  // true when the address names a mapped register
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `ADDR_CONTROL_2) || (a == `ADDR_IRQ_STATUS) ||
               (a == `ADDR_IRQ_MASK) || (a == `ADDR_LINE_STATUS);
    end
  endfunction

  // byte-lane merge of a 16-bit register with the write strobes
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // commit once address and data are both held and no answer still waits
  assign doWrite = awHeld_reg & wHeld_reg & ~bvalid;

  // trigger input comes from another timer, so synchronise it first
  always @(posedge clk) begin
    if (srst) begin
      trigSync1_reg <= 1'b0;
      trigSync2_reg <= 1'b0;
      trigLast_reg  <= 1'b0;
    end else begin
      trigSync1_reg <= triggerInput;
      trigSync2_reg <= trigSync1_reg;
      trigLast_reg  <= trigSync2_reg;
    end
  end
  // one-cycle pulse on a rising edge of the synchronised trigger
  assign trigRise = trigSync2_reg & ~trigLast_reg;

  // write path: address and data taken in either order, then response
  always @(posedge clk) begin
    if (srst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg  <= 32'h0000_0000;
      wStrb_reg  <= 4'h0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
    end else begin
      // a pending answer blocks new address and data until bready
      awready <= ~awHeld_reg & ~awready & awvalid & ~bvalid;
      wready  <= ~wHeld_reg & ~wready & wvalid & ~bvalid;
      if (awvalid & awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid & wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= mapped(awAddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // next control value: reserved bits stay zero, idle bits honour lock
  always @* begin
    writeHit = doWrite & (awAddr_reg == `ADDR_CONTROL_2);
    control2_next = control2_reg;
    if (writeHit) begin
      control2_next = merge16(control2_reg, wData_reg, wStrb_reg) &
                      `CONTROL_2_WMASK;
      if (lockLevel != `LOCK_OFF) begin
        control2_next[`IDLE_MSB:`IDLE_LSB] =
          control2_reg[`IDLE_MSB:`IDLE_LSB];
      end
    end
  end

  // event sources for the sticky status
  always @* begin
    irqEvents = 4'h0;
    irqEvents[`IRQ_UPDATE]    = updateEvent;
    irqEvents[`IRQ_MATCH]     = compareMatch;
    irqEvents[`IRQ_TRIG_RISE] = trigRise;
    irqEvents[`IRQ_PRELOAD]   = preloadLoad;
  end

  // registers; a new event wins over a write-one-to-clear
  always @(posedge clk) begin
    if (srst) begin
      control2_reg  <= `CONTROL_2_RESET;
      irqStatus_reg <= 4'h0;
      irqMask_reg   <= 4'h0;
      irq           <= 1'b0;
    end else begin
      control2_reg <= control2_next;
      if (doWrite & (awAddr_reg == `ADDR_IRQ_STATUS) & wStrb_reg[0]) begin
        irqStatus_reg <= (irqStatus_reg & ~wData_reg[3:0]) | irqEvents;
      end else begin
        irqStatus_reg <= irqStatus_reg | irqEvents;
      end
      if (doWrite & (awAddr_reg == `ADDR_IRQ_MASK) & wStrb_reg[0]) begin
        irqMask_reg <= wData_reg[3:0];
      end
      // one cycle behind the status, so the pin leaves a flop
      irq <= |(irqStatus_reg & irqMask_reg);
    end
  end

  // read path: one cycle to arready, one more to rvalid
  always @(posedge clk) begin
    if (srst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else begin
      // a pending read answer blocks the next read address
      arready <= arvalid & ~arready & ~rvalid;
      if (arvalid & arready) begin
        rvalid <= 1'b1;
        rresp  <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (araddr)
          `ADDR_CONTROL_2:   rdata <= {16'h0000, control2_reg};
          `ADDR_IRQ_STATUS:  rdata <= {28'h000_0000, irqStatus_reg};
          `ADDR_IRQ_MASK:    rdata <= {28'h000_0000, irqMask_reg};
          `ADDR_LINE_STATUS: rdata <= {16'h0000, compOutput, mainOutput,
                                       7'h00, masterTriggerOut};
          default:           rdata <= 32'h0000_0000;
        endcase
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // per channel idle levels; comp bit sits above main bit in each pair
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      assign idleComp[ch] = control2_reg[`IDLE_LSB + 2*ch + 1];
      // main idle bit sits just below its complementary partner
      assign idleMain[ch] = control2_reg[`IDLE_LSB + 2*ch];
      // outputs drop to idle levels when the main enable is off; main of a channel without comp drops low
      always @(posedge clk) begin
        if (srst) begin
          mainOutput[ch] <= 1'b0;
          compOutput[ch] <= 1'b0;
        end else if (!mainOutputEnable) begin
          compOutput[ch] <= idleComp[ch];
          mainOutput[ch] <= HAS_COMP[ch] ?
            idleMain[ch] : 1'b0;
        end else begin
          mainOutput[ch] <= activeMain[ch];
          compOutput[ch] <= activeComp[ch];
        end
      end
      // dma request on channel event or on update event
      always @(posedge clk) begin
        if (srst) begin
          dmaRequest[ch] <= 1'b0;
        end else begin
          dmaRequest[ch] <= control2_reg[`DMA_SRC_BIT] ?
            updateEvent : capCompEvent[ch];
        end
      end
    end
  endgenerate

  // preload controls of channels with complementary outputs
  always @(posedge clk) begin
    if (srst) begin
      preloadEnable <= 1'b0;
      preloadLoad   <= 1'b0;
    end else begin
      preloadEnable <= control2_reg[`PRELOAD_EN_BIT];
      // load strobe: commutation command, or trigger edge when selected
      preloadLoad   <= control2_reg[`PRELOAD_EN_BIT] &
        (commutationGenerate |
         (control2_reg[`PRELOAD_SRC_BIT] & trigRise));
    end
  end

  // trigger selection lives in its own module
  master_trigger_select u_trig (
    .clk              (clk),
    .srst             (srst),
    .mode             (control2_reg[`MASTER_SEL_MSB:`MASTER_SEL_LSB]),
    .masterSlave      (masterSlave),
    .updateGenerate   (updateGenerate),
    .updateEvent      (updateEvent),
    .counterEnableBit (counterEnableBit),
    .gatedMode        (gatedMode),
    .triggerInput     (trigSync2_reg),
    .compareMatch     (compareMatch),
    .compareRef       (compareRef),
    .masterTriggerOut (masterTriggerOut)
  );

endmodule

// *** tb/slave_timer_model.sv ***
// slave timer model counting starts from the master trigger
`timescale 1ns/1ps
module slave_timer_model (
  // clock and reset
  input  logic       clk,
  input  logic       srst,
  // trigger from the master
  input  logic       trig,
  // starts seen so far
  output logic [7:0] starts
);
  logic trigQ;
  // a slave starts on each rising edge; a level held high starts it once
  always @(posedge clk) begin
    trigQ <= trig;
    if (srst) begin
      starts <= 8'h00;
    end else if (trig && !trigQ) begin
      starts <= starts + 8'h01;
    end
  end
endmodule

// *** tb/timer_control_two_monitor.sv ***
// concurrent checks on the second timer control block
`timescale 1ns/1ps
`include "timer_control_two_regs.vh"
module timer_control_two_monitor #(
  parameter CHANNELS = 4
) (
  // clock and reset
  input logic                clk,
  input logic                srst,
  // write bus
  input logic                awvalid,
  input logic                awready,
  input logic                wvalid,
  input logic                wready,
  input logic                bvalid,
  input logic                bready,
  input logic [7:0]          awaddr,
  input logic [31:0]         wdata,
  // timer core state
  input logic                mainOutputEnable,
  input logic                gatedMode,
  input logic                counterEnableBit,
  input logic                updateGenerate,
  input logic                updateEvent,
  input logic                compareMatch,
  input logic [1:0]          lockLevel,
  input logic [CHANNELS-1:0] compareRef,
  input logic [CHANNELS-1:0] capCompEvent,
  // outputs
  input logic [CHANNELS-1:0] mainOutput,
  input logic [CHANNELS-1:0] compOutput,
  input logic [CHANNELS-1:0] dmaRequest,
  input logic                masterTriggerOut
);
  logic [15:0]         ctl, wd;
  logic [CHANNELS-1:0] refQ;
  logic                toCtl;
  // register mirror, committed at the write answer; lock must stay steady
  always @(posedge clk) begin
    refQ <= compareRef;
    if (srst) begin
      ctl <= `CONTROL_2_RESET;
      toCtl <= 1'b0;
    end else begin
      if (awvalid && awready) toCtl <= awaddr == `ADDR_CONTROL_2;
      if (wvalid && wready) wd <= wdata[15:0] & `CONTROL_2_WMASK;
      if (bvalid && bready && toCtl)
        ctl <= lockLevel != `LOCK_OFF ? {ctl[15:8], wd[7:0]} : wd;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // no answer pending for two cycles, so the mirror equals the register
  sequence quiet; !bvalid ##1 !bvalid; endsequence
  sequence idle; (!mainOutputEnable && !bvalid)[*2]; endsequence
  a_idle_comp: assert property (
    idle |-> compOutput == {ctl[15], ctl[13], ctl[11], ctl[9]})
    else $error("comp idle level wrong");
  // every channel has a complementary output here
  a_idle_main: assert property (
    idle |-> mainOutput == {ctl[14], ctl[12], ctl[10], ctl[8]})
    else $error("main idle level wrong");
  a_trig_ugen: assert property (
    quiet ##0 (ctl[6:4] == `TRG_RESET) |->
    masterTriggerOut == $past(updateGenerate))
    else $error("update generate not forwarded");
  a_trig_enable: assert property (
    (!bvalid && !gatedMode && ctl[6:4] == `TRG_ENABLE)[*4] |->
    masterTriggerOut == $past(counterEnableBit))
    else $error("counter enable not forwarded");
  a_trig_update: assert property (
    quiet ##0 (ctl[6:4] == `TRG_UPDATE) |->
    masterTriggerOut == $past(updateEvent))
    else $error("update event not forwarded");
  a_trig_match: assert property (
    quiet ##0 (ctl[6:4] == `TRG_MATCH_PULSE) |->
    masterTriggerOut == $past(compareMatch))
    else $error("match pulse not forwarded");
  a_trig_ref: assert property (
    quiet ##0 ctl[6] |-> masterTriggerOut == refQ[ctl[5:4]])
    else $error("compare reference not forwarded");
  a_dma_source: assert property (
    quiet |-> dmaRequest == (ctl[`DMA_SRC_BIT] ?
    {CHANNELS{$past(updateEvent)}} : $past(capCompEvent)))
    else $error("dma request source wrong");
endmodule

// *** tb/test_adv_timer_control_two.sv ***
// testbench of the second timer control block
`timescale 1ns/1ps
`include "timer_control_two_regs.vh"
module test_adv_timer_control_two;
  logic        clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
  logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        mainOutputEnable = 1'b0, counterEnableBit = 1'b0;
  logic        gatedMode = 1'b0, masterSlave = 1'b0, triggerInput = 1'b0;
  logic        updateGenerate = 1'b0, updateEvent = 1'b0;
  logic        compareMatch = 1'b0, commutationGenerate = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, starts;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  wstrb = 4'hF, compareRef = 4'h0, capCompEvent = 4'h0;
  logic [3:0]  activeMain = 4'h0, activeComp = 4'h0;
  logic [3:0]  mainOutput, compOutput, dmaRequest;
  logic [1:0]  lockLevel = 2'b00, bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, masterTriggerOut;
  logic        preloadLoad, preloadEnable, irq;
  int          miscompares = 0, samplesChecked = 0, cycles = 0;

  adv_timer_control_two uut (
    .clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mainOutputEnable(mainOutputEnable), .lockLevel(lockLevel),
    .counterEnableBit(counterEnableBit), .gatedMode(gatedMode),
    .masterSlave(masterSlave), .triggerInput(triggerInput),
    .updateGenerate(updateGenerate), .updateEvent(updateEvent),
    .commutationGenerate(commutationGenerate), .compareMatch(compareMatch),
    .compareRef(compareRef), .capCompEvent(capCompEvent),
    .activeMain(activeMain), .activeComp(activeComp),
    .mainOutput(mainOutput), .compOutput(compOutput),
    .masterTriggerOut(masterTriggerOut), .dmaRequest(dmaRequest),
    .preloadLoad(preloadLoad), .preloadEnable(preloadEnable), .irq(irq));
  slave_timer_model slave (.clk(clk), .srst(srst),
    .trig(masterTriggerOut), .starts(starts));

  // clock and hang guard
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, got);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // the two bus tasks release each channel at the edge that takes it
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask
  task automatic expectRead(input logic [7:0] a, input logic [31:0] e,
                            input logic [1:0] er);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    check("rdata", e, rdata);
    check("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
  endtask

  task automatic testMap();
    expectRead(`ADDR_CONTROL_2, 32'h0000_0000, `RESP_OKAY);
    axiWrite(8'h40, 32'h0000_FFFF, `RESP_SLVERR);
    expectRead(8'h40, 32'h0000_0000, `RESP_SLVERR);
  endtask
  task automatic testIdle();
    @(posedge clk);
    mainOutputEnable <= 1'b1; activeMain <= 4'hA; activeComp <= 4'h6;
    axiWrite(`ADDR_CONTROL_2, 32'h0000_A500, `RESP_OKAY);
    ticks(3);
    check("active main", 32'h0000_000A, {28'h0, mainOutput});
    check("active comp", 32'h0000_0006, {28'h0, compOutput});
    @(posedge clk);
    mainOutputEnable <= 1'b0;
    ticks(3);
    check("comp idle", 32'h0000_000C, 32'(compOutput));
    check("main idle", 32'h0000_0003, 32'(mainOutput));
  endtask
  // each lock level from 1 to 3 freezes the idle bits, other fields still move
  task automatic testLock();
    for (int lv = 1; lv < 4; lv++) begin
      @(posedge clk);
      lockLevel <= lv[1:0];
      axiWrite(`ADDR_CONTROL_2, 32'h0000_5A10, `RESP_OKAY);
      expectRead(`ADDR_CONTROL_2, 32'h0000_A510, `RESP_OKAY);
    end
    @(posedge clk);
    lockLevel <= 2'b00;
  endtask
  // one source pulse per mode gives exactly one slave start
  task automatic testModes();
    logic [7:0] n;
    for (int m = 0; m < 8; m++) begin
      axiWrite(`ADDR_CONTROL_2, 32'(m << 4), `RESP_OKAY);
      n = starts + 8'h01;
      @(posedge clk);
      case (m)
        0: updateGenerate <= 1'b1;
        1: counterEnableBit <= 1'b1;
        2: updateEvent <= 1'b1;
        3: compareMatch <= 1'b1;
        default: compareRef <= 4'h1 << (m - 4);
      endcase
      @(posedge clk);
      {updateGenerate, counterEnableBit, updateEvent, compareMatch} <= 4'h0;
      compareRef <= 4'h0;
      ticks(3);
      if (m < 2) begin
        check("starts", {24'h0, n}, {24'h0, starts});
      end else if (m < 4) begin
        check("starts", {24'h0, n}, {24'h0, starts});
      end else begin
        check("starts", {24'h0, n}, {24'h0, starts});
      end
    end
  endtask
  // gated enable by the trigger input, without and with master/slave
  task automatic testLag();
    int lag[2];
    axiWrite(`ADDR_CONTROL_2, 32'h0000_0010, `RESP_OKAY);
    @(posedge clk);
    gatedMode <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      masterSlave <= s[0];
      @(posedge clk);
      triggerInput <= 1'b1;
      lag[s] = 0;
      do begin
        @(posedge clk);
        lag[s]++;
      end while (masterTriggerOut !== 1'b1 && lag[s] < 20);
      triggerInput <= 1'b0;
      ticks(8);
    end
    check("lag", 32'h0000_0001, 32'(lag[0] - lag[1]));
    @(posedge clk);
    gatedMode <= 1'b0;
  endtask
  task automatic testDmaPreload();
    logic hit = 1'b0;
    axiWrite(`ADDR_CONTROL_2, 32'h0000_0005, `RESP_OKAY);
    ticks(1);
    check("preload en", 32'h0000_0001, {31'h0, preloadEnable});
    @(posedge clk);
    capCompEvent <= 4'h5;
    triggerInput <= 1'b1;
    @(posedge clk);
    capCompEvent <= 4'h0;
    #1;
    check("dma event", 32'h0000_0005, {28'h0, dmaRequest});
    repeat (6) begin
      @(posedge clk);
      hit |= preloadLoad;
    end
    triggerInput <= 1'b0;
    check("trig load", 32'h0000_0001, {31'h0, hit});
    axiWrite(`ADDR_CONTROL_2, 32'h0000_0008, `RESP_OKAY);
    @(posedge clk);
    updateEvent <= 1'b1;
    @(posedge clk);
    updateEvent <= 1'b0;
    #1;
    check("dma update", 32'h0000_000F, {28'h0, dmaRequest});
  endtask
  // raise, clear and mask the update interrupt
  task automatic testIrq();
    axiWrite(`ADDR_IRQ_MASK, 32'h0000_0001, `RESP_OKAY);
    ticks(3);
    check("irq set", 32'h0000_0001, {31'h0, irq});
    axiWrite(`ADDR_IRQ_STATUS, 32'h0000_000F, `RESP_OKAY);
    axiWrite(`ADDR_IRQ_MASK, 32'h0000_0000, `RESP_OKAY);
    @(posedge clk);
    updateEvent <= 1'b1;
    @(posedge clk);
    updateEvent <= 1'b0;
    ticks(3);
    check("irq masked", 32'h0000_0000, {31'h0, irq});
    expectRead(`ADDR_IRQ_STATUS, 32'h0000_0001, `RESP_OKAY);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    testMap();
    testIdle();
    testLock();
    testModes();
    testLag();
    testDmaPreload();
    testIrq();
    summarize();
  end
endmodule

bind adv_timer_control_two timer_control_two_monitor #(.CHANNELS(CHANNELS))
  mon (.clk(clk), .srst(srst), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .awaddr(awaddr), .wdata(wdata), .mainOutputEnable(mainOutputEnable),
  .gatedMode(gatedMode), .counterEnableBit(counterEnableBit),
  .updateGenerate(updateGenerate), .updateEvent(updateEvent),
  .compareMatch(compareMatch), .lockLevel(lockLevel),
  .compareRef(compareRef), .capCompEvent(capCompEvent),
  .mainOutput(mainOutput), .compOutput(compOutput),
  .dmaRequest(dmaRequest), .masterTriggerOut(masterTriggerOut));
